// [tmr_map.svh]
// Purpose: Offsets-free constant map for the 8-bit timer block
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Field positions, reset values and prescaler tap widths
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_BOTTOM      8'h00
`define TMR_MAX         8'hFF
`define TMR_MAX_LESS1   8'hFE
`define TMR_ONE         8'h01
`define TMR_RESET_BYTE  8'h00
`define TMR_PSC_WIDTH   10
`define TMR_DIV8_BITS   3
`define TMR_DIV64_BITS  6
`define TMR_DIV256_BITS 8
`define TMR_DIV1024_BITS 10
`define TMR_TAP_DIV8    0
`define TMR_TAP_DIV64   1
`define TMR_TAP_DIV256  2
`define TMR_TAP_DIV1024 3

`endif

// [tmr_pkg.sv]
// Purpose: Types shared by the 8-bit timer files
// Assumes: Nothing
// Notes:   Mode codes follow the waveform mode field encoding
package tmr_pkg;

    typedef enum logic [1:0] {
        TMR_MODE_NORMAL = 2'b00,
        TMR_MODE_PHASE  = 2'b01,
        TMR_MODE_CTC    = 2'b10,
        TMR_MODE_FAST   = 2'b11
    } tmr_mode_t;

    typedef enum logic [2:0] {
        TMR_SRC_STOP     = 3'b000,
        TMR_SRC_DIRECT   = 3'b001,
        TMR_SRC_DIV8     = 3'b010,
        TMR_SRC_DIV64    = 3'b011,
        TMR_SRC_DIV256   = 3'b100,
        TMR_SRC_DIV1024  = 3'b101,
        TMR_SRC_EXT_FALL = 3'b110,
        TMR_SRC_EXT_RISE = 3'b111
    } tmr_src_t;

    typedef enum logic [1:0] {
        TMR_ACT_NONE   = 2'b00,
        TMR_ACT_TOGGLE = 2'b01,
        TMR_ACT_CLEAR  = 2'b10,
        TMR_ACT_SET    = 2'b11
    } tmr_act_t;

endpackage

// [tmr_prescaler.sv]
// Purpose: Shared free-running prescaler with its reset bit
// Assumes: rstN already synchronised to clock
// Notes:   Taps are one-cycle pulses, used by every timer on the chain
`timescale 1ns/10ps
`default_nettype none
`include "tmr_map.svh"
module tmr_prescaler
#(
    parameter int WIDTH = `TMR_PSC_WIDTH
)
(
    input  wire logic         clock,
    input  wire logic         rstN,
    input  wire logic         resetWrite,
    input  wire logic         syncHoldMode,
    output var  logic         resetBit,
    output var  logic [3:0]   tapPulse
);

    generate
        if (WIDTH < `TMR_DIV1024_BITS)
            $error("Prescaler too narrow for the divide-by-1024 tap");
    endgenerate

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             resetBit_next;
    logic [3:0]       tap_next;

    always_comb
    begin
        // Hold mode keeps the bit, otherwise it lives one cycle
        resetBit_next = resetWrite | (resetBit & syncHoldMode);
        count_next    = resetBit ? '0 : count_reg + 1'b1;
        tap_next[`TMR_TAP_DIV8]    = &count_reg[`TMR_DIV8_BITS-1:0];
        tap_next[`TMR_TAP_DIV64]   = &count_reg[`TMR_DIV64_BITS-1:0];
        tap_next[`TMR_TAP_DIV256]  = &count_reg[`TMR_DIV256_BITS-1:0];
        tap_next[`TMR_TAP_DIV1024] = &count_reg[`TMR_DIV1024_BITS-1:0];
        if (resetBit)
            tap_next = 4'h0;
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            count_reg <= '0;
            resetBit  <= 1'b0;
            tapPulse  <= 4'h0;
        end
        else
        begin
            count_reg <= count_next;
            resetBit  <= resetBit_next;
            tapPulse  <= tap_next;
        end
    end

endmodule // tmr_prescaler
`default_nettype wire

// [tmr_timer8.sv]
// Purpose: 8-bit timer/counter with output compare and shared prescaler
// Assumes: Control inputs come from logic on clock; ext pin is async
// Notes:   Function
`timescale 1ns/10ps
`default_nettype none
`include "tmr_map.svh"
module tmr_timer8
(
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic         countWrite,
    input  wire logic [7:0]   countWrData,
    input  wire logic         compareWrite,
    input  wire logic [7:0]   compareWrData,
    input  wire logic         controlWrite,
    input  wire logic [2:0]   tickSourceSelect,
    input  wire logic [1:0]   waveformModeField,
    input  wire logic [1:0]   compareOutputField,
    input  wire logic         forceCompareStrobe,
    input  wire logic         maskWrite,
    input  wire logic         compareIrqEnable,
    input  wire logic         overflowIrqEnable,
    input  wire logic         flagWrite,
    input  wire logic         flagWrMatch,
    input  wire logic         flagWrOverflow,
    input  wire logic         irqServiceCompare,
    input  wire logic         irqServiceOverflow,
    input  wire logic         globalIrqEnable,
    input  wire logic         prescalerResetWrite,
    input  wire logic         syncHoldMode,
    input  wire logic         extCountPin,
    output var  logic [7:0]   countValue,
    output var  logic [7:0]   compareValue,
    output var  logic         compareMatchFlag,
    output var  logic         overflowFlag,
    output var  logic         compareIrq,
    output var  logic         overflowIrq,
    output var  logic         compareOutput,
    output var  logic         sharedPrescalerReset,
    output var  logic [3:0]   prescalerTaps
);

    logic                 rstMeta_reg;
    logic                 rstN;
    logic                 extMeta_reg;
    logic                 extSync_reg;
    logic                 extPrev_reg;
    tmr_pkg::tmr_src_t    srcSel_reg;
    tmr_pkg::tmr_mode_t   mode_reg;
    logic [1:0]           comField_reg;
    logic                 cmpEn_reg;
    logic                 ovfEn_reg;
    logic [7:0]           ocrActive_reg;
    logic [7:0]           ocrBuffer_reg;
    logic                 down_reg;
    logic                 block_reg;
    logic                 tick;
    logic                 atBottom;
    logic                 atMax;
    logic [7:0]           topValue;
    logic                 buffered;
    logic                 matchEvt;
    logic [7:0]           count_next;
    logic                 down_next;
    logic                 block_next;
    logic                 ovfSet;
    logic [7:0]           ocrActive_next;
    logic [7:0]           ocrBuffer_next;
    logic [7:0]           compareValue_next;
    logic                 matchFlag_next;
    logic                 ovfFlag_next;
    logic                 compareOutput_next;
    tmr_pkg::tmr_act_t    action;

    // Non-PWM compare output action from the field
    function automatic tmr_pkg::tmr_act_t nonPwmAct(input logic [1:0] com);
        return tmr_pkg::tmr_act_t'(com);
    endfunction

    function automatic logic applyAct(input logic oc,
                                      input tmr_pkg::tmr_act_t act);
        unique case (act)
            tmr_pkg::TMR_ACT_NONE:   return oc;
            tmr_pkg::TMR_ACT_TOGGLE: return ~oc;
            tmr_pkg::TMR_ACT_CLEAR:  return 1'b0;
            tmr_pkg::TMR_ACT_SET:    return 1'b1;
        endcase
    endfunction

    // Reset release through two flops
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_reg <= 1'b0;
            rstN        <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstN        <= rstMeta_reg;
        end
    end

    tmr_prescaler u_prescaler
    (
        .clock        (clock),
        .rstN         (rstN),
        .resetWrite   (prescalerResetWrite),
        .syncHoldMode (syncHoldMode),
        .resetBit     (sharedPrescalerReset),
        .tapPulse     (prescalerTaps)
    );

    // Tick selection; edge detector compares the second sync flop with its delayed copy
    always_comb
    begin
        unique case (srcSel_reg)
            tmr_pkg::TMR_SRC_STOP:     tick = 1'b0;
            tmr_pkg::TMR_SRC_DIRECT:   tick = 1'b1;
            tmr_pkg::TMR_SRC_DIV8:     tick = prescalerTaps[`TMR_TAP_DIV8];
            tmr_pkg::TMR_SRC_DIV64:    tick = prescalerTaps[`TMR_TAP_DIV64];
            tmr_pkg::TMR_SRC_DIV256:   tick = prescalerTaps[`TMR_TAP_DIV256];
            tmr_pkg::TMR_SRC_DIV1024:  tick = prescalerTaps[`TMR_TAP_DIV1024];
            tmr_pkg::TMR_SRC_EXT_FALL: tick = extPrev_reg & ~extSync_reg;
            tmr_pkg::TMR_SRC_EXT_RISE: tick = ~extPrev_reg & extSync_reg;
        endcase
    end

    assign atBottom = (countValue == `TMR_BOTTOM);
    assign atMax    = (countValue == `TMR_MAX);
    assign topValue = (mode_reg == tmr_pkg::TMR_MODE_CTC) ? ocrActive_reg
                                                        : `TMR_MAX;
    assign buffered = (mode_reg == tmr_pkg::TMR_MODE_PHASE) ||
                      (mode_reg == tmr_pkg::TMR_MODE_FAST);
    assign matchEvt = tick && (countValue == ocrActive_reg) && !block_reg;

    // Counter group
    always_comb
    begin
        count_next = countValue;
        down_next  = down_reg;
        ovfSet     = 1'b0;
        block_next = countWrite | (block_reg & ~tick);
        if (tick)
        begin
            unique case (mode_reg)
                tmr_pkg::TMR_MODE_NORMAL, tmr_pkg::TMR_MODE_FAST:
                begin
                    count_next = 8'(countValue + `TMR_ONE);
                    down_next  = 1'b0;
                    ovfSet     = atMax;
                end
                tmr_pkg::TMR_MODE_CTC:
                begin
                    down_next  = 1'b0;
                    ovfSet     = atMax;
                    if (matchEvt && countValue == topValue)
                        count_next = `TMR_BOTTOM;
                    else
                        count_next = 8'(countValue + `TMR_ONE);
                end
                tmr_pkg::TMR_MODE_PHASE:
                begin
                    if (!down_reg && atMax)
                    begin
                        down_next  = 1'b1;
                        count_next = `TMR_MAX_LESS1;
                    end
                    else if (down_reg && atBottom)
                    begin
                        down_next  = 1'b0;
                        count_next = `TMR_ONE;
                        ovfSet     = 1'b1;
                    end
                    else if (down_reg)
                        count_next = 8'(countValue - `TMR_ONE);
                    else
                        count_next = 8'(countValue + `TMR_ONE);
                end
            endcase
        end
        if (countWrite)
            count_next = countWrData;
    end

    // Compare register group
    always_comb
    begin
        ocrActive_next = ocrActive_reg;
        ocrBuffer_next = ocrBuffer_reg;
        if (buffered && tick && atMax)
            ocrActive_next = ocrBuffer_reg;
        if (compareWrite)
        begin
            if (buffered)
                ocrBuffer_next = compareWrData;
            else
                ocrActive_next = compareWrData;
        end
        compareValue_next = buffered ? ocrBuffer_next : ocrActive_next;
    end

    // Compare output and flag group; a flag set beats a clear
    always_comb
    begin
        action = tmr_pkg::TMR_ACT_NONE;
        if (matchEvt)
        begin
            unique case (mode_reg)
                tmr_pkg::TMR_MODE_NORMAL, tmr_pkg::TMR_MODE_CTC:
                    action = nonPwmAct(comField_reg);
                tmr_pkg::TMR_MODE_FAST:
                    action = comField_reg[1] ? (comField_reg[0] ?
                             tmr_pkg::TMR_ACT_SET : tmr_pkg::TMR_ACT_CLEAR)
                             : tmr_pkg::TMR_ACT_NONE;
                tmr_pkg::TMR_MODE_PHASE:
                    action = !comField_reg[1] ? tmr_pkg::TMR_ACT_NONE :
                             ((comField_reg[0] ^ down_reg) ?
                             tmr_pkg::TMR_ACT_SET : tmr_pkg::TMR_ACT_CLEAR);
            endcase
        end
        // Fast PWM bottom restores the idle level after the match
        if (mode_reg == tmr_pkg::TMR_MODE_FAST && tick && atMax &&
            comField_reg[1])
            action = comField_reg[0] ? tmr_pkg::TMR_ACT_CLEAR
                                     : tmr_pkg::TMR_ACT_SET;
        if (forceCompareStrobe && !buffered)
            action = nonPwmAct(comField_reg);
        compareOutput_next = applyAct(compareOutput, action);
        matchFlag_next = matchEvt | (compareMatchFlag &
                         ~(irqServiceCompare | (flagWrite & flagWrMatch)));
        ovfFlag_next   = ovfSet | (overflowFlag &
                         ~(irqServiceOverflow | (flagWrite & flagWrOverflow)));
    end

    always_ff @(posedge clock or negedge rstN)
    begin
        if (!rstN)
        begin
            extMeta_reg      <= 1'b0;
            extSync_reg      <= 1'b0;
            extPrev_reg      <= 1'b0;
            srcSel_reg       <= tmr_pkg::TMR_SRC_STOP;
            mode_reg         <= tmr_pkg::TMR_MODE_NORMAL;
            comField_reg     <= 2'h0;
            cmpEn_reg        <= 1'b0;
            ovfEn_reg        <= 1'b0;
            countValue       <= `TMR_RESET_BYTE;
            down_reg         <= 1'b0;
            block_reg        <= 1'b0;
            ocrActive_reg    <= `TMR_RESET_BYTE;
            ocrBuffer_reg    <= `TMR_RESET_BYTE;
            compareValue     <= `TMR_RESET_BYTE;
            compareOutput    <= 1'b0;
            compareMatchFlag <= 1'b0;
            overflowFlag     <= 1'b0;
            compareIrq       <= 1'b0;
            overflowIrq      <= 1'b0;
        end
        else
        begin
            extMeta_reg      <= extCountPin;
            extSync_reg      <= extMeta_reg;
            extPrev_reg      <= extSync_reg;
            if (controlWrite)
            begin
                srcSel_reg   <= tmr_pkg::tmr_src_t'(tickSourceSelect);
                mode_reg     <= tmr_pkg::tmr_mode_t'(waveformModeField);
                comField_reg <= compareOutputField;
            end
            if (maskWrite)
            begin
                cmpEn_reg    <= compareIrqEnable;
                ovfEn_reg    <= overflowIrqEnable;
            end
            countValue       <= count_next;
            down_reg         <= down_next;
            block_reg        <= block_next;
            ocrActive_reg    <= ocrActive_next;
            ocrBuffer_reg    <= ocrBuffer_next;
            compareValue     <= compareValue_next;
            compareOutput    <= compareOutput_next;
            compareMatchFlag <= matchFlag_next;
            overflowFlag     <= ovfFlag_next;
            compareIrq  <= matchFlag_next & cmpEn_reg & globalIrqEnable;
            overflowIrq <= ovfFlag_next & ovfEn_reg & globalIrqEnable;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    count_write_a: assert property (
        countWrite |=> countValue == $past(countWrData))
        else $error("Count write did not win");
    stopped_hold_a: assert property (
        srcSel_reg == tmr_pkg::TMR_SRC_STOP && !countWrite
        |=> $stable(countValue))
        else $error("Stopped counter moved");
    normal_wrap_a: assert property (
        mode_reg == tmr_pkg::TMR_MODE_NORMAL && tick && atMax && !countWrite
        |=> countValue == `TMR_BOTTOM && overflowFlag)
        else $error("Normal wrap or overflow flag wrong");
    match_flag_a: assert property (
        tick && countValue == ocrActive_reg && !block_reg
        |=> compareMatchFlag)
        else $error("Match flag not set after match tick");
    match_block_a: assert property (
        block_reg && tick && !compareMatchFlag |=> !compareMatchFlag)
        else $error("Blocked match set the flag");
    irq_gate_a: assert property (
        compareIrq |-> compareMatchFlag && $past(cmpEn_reg) &&
        $past(globalIrqEnable))
        else $error("Compare irq without flag or enables");
    flag_clear_a: assert property (
        compareMatchFlag && irqServiceCompare && !matchEvt
        |=> !compareMatchFlag)
        else $error("Serviced flag not cleared");
    buffer_hold_a: assert property (
        buffered && compareWrite && !(tick && atMax)
        |=> ocrActive_reg == $past(ocrActive_reg))
        else $error("Buffered write reached active compare");
    force_out_a: assert property (
        forceCompareStrobe && !buffered && !matchEvt && comField_reg == 2'h1
        |=> compareOutput != $past(compareOutput) && !$rose(compareMatchFlag))
        else $error("Force strobe mishandled");
    psc_clear_a: assert property (
        sharedPrescalerReset && !syncHoldMode && !prescalerResetWrite
        |=> !sharedPrescalerReset)
        else $error("Prescaler reset bit not self-cleared");
    phase_turn_a: assert property (
        mode_reg == tmr_pkg::TMR_MODE_PHASE && tick && atMax && !down_reg &&
        !countWrite |=> countValue == `TMR_MAX_LESS1 && down_reg)
        else $error("Phase-correct turn at top wrong");

    ctc_clear_c: cover property (
        mode_reg == tmr_pkg::TMR_MODE_CTC && matchEvt ##1 atBottom);
    phase_bottom_c: cover property (
        mode_reg == tmr_pkg::TMR_MODE_PHASE && down_reg && atBottom && tick);
    ovf_irq_c: cover property ($rose(overflowIrq));
    ext_tick_c: cover property (
        srcSel_reg == tmr_pkg::TMR_SRC_EXT_RISE && tick);

endmodule // tmr_timer8
`default_nettype wire

// [tmr_timer8_bench.sv]
// Purpose: Self-checking bench for the 8-bit timer/counter
// Assumes: Inputs driven on rising edge, outputs sampled on falling edge
// Notes:   Direct tick source keeps runs short
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tmr_timer8_bench;
    logic       clock, arst_n, countWrite, compareWrite, controlWrite;
    logic       forceCompareStrobe, maskWrite, compareIrqEnable;
    logic       overflowIrqEnable, flagWrite, flagWrMatch, flagWrOverflow;
    logic       irqServiceCompare, irqServiceOverflow, globalIrqEnable;
    logic       prescalerResetWrite, syncHoldMode, extCountPin;
    logic [7:0] countWrData, compareWrData, countValue, compareValue;
    logic [2:0] tickSourceSelect;
    logic [1:0] waveformModeField, compareOutputField;
    logic       compareMatchFlag, overflowFlag, compareIrq, overflowIrq;
    logic       compareOutput, sharedPrescalerReset;
    logic [3:0] prescalerTaps;
    int         failCount, nChecks, cycles;

    tmr_timer8 DUT (.clock(clock), .arst_n(arst_n), .countWrite(countWrite),
        .countWrData(countWrData), .compareWrite(compareWrite),
        .compareWrData(compareWrData), .controlWrite(controlWrite),
        .tickSourceSelect(tickSourceSelect),
        .waveformModeField(waveformModeField),
        .compareOutputField(compareOutputField),
        .forceCompareStrobe(forceCompareStrobe), .maskWrite(maskWrite),
        .compareIrqEnable(compareIrqEnable),
        .overflowIrqEnable(overflowIrqEnable), .flagWrite(flagWrite),
        .flagWrMatch(flagWrMatch), .flagWrOverflow(flagWrOverflow),
        .irqServiceCompare(irqServiceCompare),
        .irqServiceOverflow(irqServiceOverflow),
        .globalIrqEnable(globalIrqEnable),
        .prescalerResetWrite(prescalerResetWrite),
        .syncHoldMode(syncHoldMode), .extCountPin(extCountPin),
        .countValue(countValue), .compareValue(compareValue),
        .compareMatchFlag(compareMatchFlag), .overflowFlag(overflowFlag),
        .compareIrq(compareIrq), .overflowIrq(overflowIrq),
        .compareOutput(compareOutput),
        .sharedPrescalerReset(sharedPrescalerReset),
        .prescalerTaps(prescalerTaps));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task endSim;
        if (failCount == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Ceiling well above the few thousand cycles the sequence needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failCount++;
            endSim();
        end
    end

    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task setCount(input logic [7:0] v);
        @(posedge clock) begin countWrite <= 1'b1; countWrData <= v; end
        @(posedge clock) countWrite <= 1'b0;
        @(negedge clock);
    endtask

    task setCmp(input logic [7:0] v);
        @(posedge clock) begin compareWrite <= 1'b1; compareWrData <= v; end
        @(posedge clock) compareWrite <= 1'b0;
        @(negedge clock);
    endtask

    task setCtl(input logic [2:0] s, input logic [1:0] m, input logic [1:0] c);
        @(posedge clock)
        begin
            controlWrite <= 1'b1;
            tickSourceSelect <= s;
            waveformModeField <= m;
            compareOutputField <= c;
        end
        @(posedge clock) controlWrite <= 1'b0;
        @(negedge clock);
    endtask

    // Strobes and levels other than the count, compare and control writes change here, on a rising edge
    localparam int FLAG_WR = 0, MASK_WR = 1, SERVICE = 2, FORCE = 3;
    localparam int PSC_WR = 4, WR_MATCH = 5, WR_OVF = 6, CMP_EN = 7;
    localparam int GLOBAL_EN = 8, SYNC_HOLD = 9, EXT_PIN = 10;

    task drive(input int k, input logic v);
        case (k)
            FLAG_WR:   flagWrite <= v;
            MASK_WR:   maskWrite <= v;
            SERVICE:   irqServiceCompare <= v;
            FORCE:     forceCompareStrobe <= v;
            PSC_WR:    prescalerResetWrite <= v;
            WR_MATCH:  flagWrMatch <= v;
            WR_OVF:    flagWrOverflow <= v;
            CMP_EN:    compareIrqEnable <= v;
            GLOBAL_EN: globalIrqEnable <= v;
            SYNC_HOLD: syncHoldMode <= v;
            default:   extCountPin <= v;
        endcase
    endtask

    task pulse(input int k);
        @(posedge clock) drive(k, 1'b1);
        @(posedge clock) drive(k, 1'b0);
        @(negedge clock);
    endtask

    task setLvl(input int k, input logic v);
        @(posedge clock) drive(k, v);
        @(negedge clock);
    endtask

    // Any window of 2N edges holds exactly two divide-by-N taps
    task tapRun(input logic [2:0] s, input int n);
        setCtl(s, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        setCount(8'h40);
        cyc(2 * n);
        `CHK(countValue, 8'h42)
    endtask

    // Bounded wait so a stuck counter ends in a mismatch, not a hang
    task waitCnt(input logic [7:0] v);
        int i;
        for (i = 0; i < 600 && countValue !== v; i++)
            @(negedge clock);
        `CHK(countValue, v)
    endtask

    initial
    begin
        {arst_n, countWrite, compareWrite, controlWrite, forceCompareStrobe,
         maskWrite, compareIrqEnable, overflowIrqEnable, flagWrite,
         flagWrMatch, flagWrOverflow, irqServiceCompare, irqServiceOverflow,
         globalIrqEnable, prescalerResetWrite, syncHoldMode,
         extCountPin} = 17'h0_0000;
        {countWrData, compareWrData} = 16'h0000;
        {tickSourceSelect, waveformModeField, compareOutputField} = 7'h00;
        failCount = 0;
        nChecks = 0;
        cycles = 0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK({countValue, compareValue, compareMatchFlag, overflowFlag,
              compareIrq, overflowIrq, compareOutput,
              sharedPrescalerReset}, 22'h00_0000)
        setCount(8'h5A);
        cyc(5);
        `CHK(countValue, 8'h5A)
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        setCount(8'hFD);
        `CHK(countValue, 8'hFD)
        waitCnt(8'h00);
        `CHK(overflowFlag, 1'b1)
        pulse(FLAG_WR);
        `CHK({overflowFlag, compareMatchFlag}, 2'h3)
        setLvl(WR_OVF, 1'b1);
        setLvl(WR_MATCH, 1'b1);
        pulse(FLAG_WR);
        `CHK({overflowFlag, compareMatchFlag}, 2'h0)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        setCmp(8'h20);
        `CHK(compareValue, 8'h20)
        setCount(8'h1E);
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        waitCnt(8'h20);
        `CHK(compareMatchFlag, 1'b0)
        cyc(2);
        `CHK(compareMatchFlag, 1'b1)
        setLvl(CMP_EN, 1'b1);
        pulse(MASK_WR);
        cyc(2);
        `CHK(compareIrq, 1'b0)
        setLvl(GLOBAL_EN, 1'b1);
        cyc(3);
        `CHK({compareIrq, overflowIrq}, 2'h2)
        pulse(SERVICE);
        cyc(1);
        `CHK({compareMatchFlag, compareIrq}, 2'h0)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_NORMAL, 2'h1);
        setCount(8'h20);
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_NORMAL, 2'h1);
        cyc(4);
        `CHK({compareMatchFlag, compareOutput}, 2'h0)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_NORMAL, 2'h1);
        pulse(FORCE);
        `CHK({compareOutput, compareMatchFlag}, 2'h2)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_FAST, 2'h1);
        pulse(FORCE);
        `CHK(compareOutput, 1'b1)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_CTC, 2'h0);
        setCmp(8'h05);
        setCount(8'h00);
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_CTC, 2'h0);
        waitCnt(8'h05);
        cyc(1);
        `CHK(countValue, 8'h00)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_PHASE, 2'h0);
        setCount(8'hFE);
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_PHASE, 2'h0);
        waitCnt(8'hFF);
        cyc(1);
        `CHK(countValue, 8'hFE)
        setCmp(8'h77);
        `CHK(compareValue, 8'h77)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        // Readback follows the new mode one edge later; top loaded buffer 0
        cyc(1);
        `CHK(compareValue, 8'h00)
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_FAST, 2'h0);
        setCmp(8'h99);
        setCount(8'hFC);
        setCtl(tmr_pkg::TMR_SRC_DIRECT, tmr_pkg::TMR_MODE_FAST, 2'h0);
        waitCnt(8'h01);
        setCtl(tmr_pkg::TMR_SRC_STOP, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        `CHK(compareValue, 8'h99)
        pulse(PSC_WR);
        `CHK(sharedPrescalerReset, 1'b1)
        cyc(1);
        `CHK(sharedPrescalerReset, 1'b0)
        setLvl(SYNC_HOLD, 1'b1);
        pulse(PSC_WR);
        cyc(20);
        `CHK({sharedPrescalerReset, prescalerTaps}, 5'h10)
        setLvl(SYNC_HOLD, 1'b0);
        cyc(2);
        `CHK(sharedPrescalerReset, 1'b0)
        cyc(6);
        `CHK(prescalerTaps[0], 1'b0)
        cyc(1);
        `CHK(prescalerTaps[0], 1'b1)
        tapRun(tmr_pkg::TMR_SRC_DIV8, 8);
        tapRun(tmr_pkg::TMR_SRC_DIV64, 64);
        tapRun(tmr_pkg::TMR_SRC_DIV256, 256);
        tapRun(tmr_pkg::TMR_SRC_DIV1024, 1024);
        setCtl(tmr_pkg::TMR_SRC_EXT_RISE, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        setCount(8'h10);
        cyc(3);
        setLvl(EXT_PIN, 1'b1);
        cyc(6);
        `CHK(countValue, 8'h11)
        setLvl(EXT_PIN, 1'b0);
        cyc(6);
        `CHK(countValue, 8'h11)
        setCtl(tmr_pkg::TMR_SRC_EXT_FALL, tmr_pkg::TMR_MODE_NORMAL, 2'h0);
        setLvl(EXT_PIN, 1'b1);
        cyc(6);
        `CHK(countValue, 8'h11)
        setLvl(EXT_PIN, 1'b0);
        cyc(6);
        `CHK(countValue, 8'h12)
        endSim();
    end
endmodule // tmr_timer8_bench
`default_nettype wire
